// ===== rtl/vcxo_divider_planner.sv
// Divider and gain planner for a programmable VCXO, APB controlled
`timescale 1ns/1ps
`include "vcxo_planner_defs.svh"

module vcxo_divider_planner #(
	parameter logic [47:0] FVCO_MAX_HZ = `FVCO_MAX_DEFAULT,
	parameter logic [27:0] FOSC_HZ     = `FOSC_DEFAULT
) (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [11:0]                       paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	output vcxo_planner_pkg::plan_result_type      plan_result,
	output logic                                   plan_done,
	output logic                                   plan_error
);
	import vcxo_planner_pkg::*;

	// ========================================
	// Declarations
	plan_state_type  state_ff;
	plan_state_type  ret_ff;
	plan_result_type result_ff;
	logic [31:0]     prdata_ff;
	logic            pready_ff;
	logic            pslverr_ff;
	logic [31:0]     fout_ff;
	logic            done_ff;
	logic            error_ff;
	logic [2:0]      ls_exp_ff;
	logic [10:0]     hs_ff;
	logic [47:0]     fvco_ff;
	logic [42:0]     fb_ff;
	logic [4:0]      nfx_ff;
	logic [65:0]     dvd_ff;
	logic [41:0]     dvs_ff;
	logic [41:0]     rem_ff;
	logic [65:0]     quo_ff;
	logic [6:0]      div_cnt_ff;
	logic            div_load;
	logic [65:0]     div_dvd;
	logic [41:0]     div_dvs;
	logic [41:0]     hs_dvs;
	logic [41:0]     trial;
	logic [47:0]     fvco_calc;
	logic [4:0]      nxt_nfx;
	logic [10:0]     nxt_hs;
	logic            rd_take;
	logic            wr_take;
	logic            start_req;
	logic [31:0]     rd_data;
	logic            rd_err;

	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;
	assign plan_result = result_ff;
	assign plan_done   = done_ff;
	assign plan_error  = error_ff;

	// ========================================
	// APB slave
	assign rd_take   = psel & penable & ~pready_ff;
	assign wr_take   = psel & penable & pready_ff & pwrite;
	assign start_req = wr_take & (paddr == `OFS_CTRL) & pwdata[`CTRL_START_BIT];

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (paddr == `OFS_CTRL) begin
			rd_data = 32'h0000_0000;
		end else if (paddr == `OFS_FOUT) begin
			rd_data = fout_ff;
		end else if (paddr == `OFS_STATUS) begin
			rd_data[`STAT_BUSY_BIT]  = (state_ff != ST_IDLE);
			rd_data[`STAT_DONE_BIT]  = done_ff;
			rd_data[`STAT_ERROR_BIT] = error_ff;
		end else if (paddr == `OFS_DIVIDERS) begin
			rd_data[`DIVS_LS_LSB +: 3]  = result_ff.low_speed_divider_exponent;
			rd_data[`DIVS_HS_LSB +: 11] = result_ff.high_speed_divider;
		end else if (paddr == `OFS_FB_FRAC) begin
			rd_data = result_ff.feedback_divider_value[31:0];
		end else if (paddr == `OFS_FB_INT) begin
			rd_data[10:0] = result_ff.feedback_divider_value[42:32];
		end else if (paddr == `OFS_GAIN) begin
			rd_data[7:0] = result_ff.control_adc_full_scale_gain;
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= rd_take;
			prdata_ff  <= (rd_take & ~pwrite) ? rd_data : 32'h0000_0000;
			pslverr_ff <= rd_take & rd_err;
		end
	end

	// Frequency request, refused while planning
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fout_ff <= 32'h0000_0000;
		end else if (wr_take && paddr == `OFS_FOUT && state_ff == ST_IDLE) begin
			fout_ff <= pwdata;
		end
	end

	// ========================================
	// Serial divider operands
	always_comb begin
		hs_dvs    = {10'h000, fout_ff} << ls_exp_ff;
		fvco_calc = (48'(fout_ff) * 48'(hs_ff)) << ls_exp_ff;
		div_load  = 1'b0;
		div_dvd   = 66'h0;
		div_dvs   = 42'h0;
		case (state_ff)
			ST_HS_LOAD: begin
				div_load = 1'b1;
				div_dvd  = 66'(`FVCO_MIN_HZ) + 66'(hs_dvs) - 66'h1;
				div_dvs  = hs_dvs;
			end
			ST_FB_LOAD: begin
				div_load = 1'b1;
				div_dvd  = {fvco_ff[33:0], 32'h0000_0000};
				div_dvs  = 42'(FOSC_HZ);
			end
			ST_GAIN_LOAD: begin
				div_load = 1'b1;
				div_dvd  = 66'(`GAIN_NUM) * 66'(nfx_ff) + 66'(fvco_ff[47:1]);
				div_dvs  = 42'(fvco_ff);
			end
			default: begin
			end
		endcase
	end

	// Rate divisor lookup on truncated integer part
	always_comb begin
		if (quo_ff[42:32] < `FEEDBACK_INTEGER_PART_TH_18) begin
			nxt_nfx = `NFX_16;
		end else if (quo_ff[42:32] < `FEEDBACK_INTEGER_PART_TH_20) begin
			nxt_nfx = `NFX_18;
		end else if (quo_ff[42:32] < `FEEDBACK_INTEGER_PART_TH_22) begin
			nxt_nfx = `NFX_20;
		end else begin
			nxt_nfx = `NFX_22;
		end
		nxt_hs = quo_ff[10:0];
		if (quo_ff[10:0] > `HS_ODD_MAX && quo_ff[0]) begin
			nxt_hs = quo_ff[10:0] + 11'h001;
		end
	end

	// ========================================
	// Restoring divider, one quotient bit per cycle
	assign trial = {rem_ff[40:0], dvd_ff[65]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dvd_ff     <= 66'h0;
			dvs_ff     <= 42'h0;
			rem_ff     <= 42'h0;
			quo_ff     <= 66'h0;
			div_cnt_ff <= 7'h00;
		end else if (div_load) begin
			dvd_ff     <= div_dvd;
			dvs_ff     <= div_dvs;
			rem_ff     <= 42'h0;
			quo_ff     <= 66'h0;
			div_cnt_ff <= `DIV_STEPS;
		end else if (div_cnt_ff != 7'h00) begin
			dvd_ff     <= {dvd_ff[64:0], 1'b0};
			div_cnt_ff <= div_cnt_ff - 7'h01;
			if (trial >= dvs_ff) begin
				rem_ff <= trial - dvs_ff;
				quo_ff <= {quo_ff[64:0], 1'b1};
			end else begin
				rem_ff <= trial;
				quo_ff <= {quo_ff[64:0], 1'b0};
			end
		end
	end

	// ========================================
	// Planning sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff  <= ST_IDLE;
			ret_ff    <= ST_IDLE;
			result_ff <= '0;
			done_ff   <= 1'b0;
			error_ff  <= 1'b0;
			ls_exp_ff <= 3'h0;
			hs_ff     <= 11'h000;
			fvco_ff   <= 48'h0;
			fb_ff     <= 43'h0;
			nfx_ff    <= 5'h00;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (start_req) begin
						done_ff   <= 1'b0;
						error_ff  <= 1'b0;
						ls_exp_ff <= 3'h0;
						if (fout_ff == 32'h0000_0000) begin
							done_ff  <= 1'b1;
							error_ff <= 1'b1;
						end else begin
							state_ff <= ST_HS_LOAD;
						end
					end
				end
				ST_HS_LOAD: begin
					ret_ff   <= ST_HS_EVAL;
					state_ff <= ST_DIVIDE;
				end
				ST_DIVIDE: begin
					if (div_cnt_ff == 7'h00) begin
						state_ff <= ret_ff;
					end
				end
				ST_HS_EVAL: begin
					if (quo_ff > 66'(`HS_MAX)) begin
						if (ls_exp_ff < `LS_MAX_EXP) begin
							ls_exp_ff <= ls_exp_ff + 3'h1;
							state_ff  <= ST_HS_LOAD;
						end else begin
							done_ff  <= 1'b1;
							error_ff <= 1'b1;
							state_ff <= ST_IDLE;
						end
					end else if (quo_ff[10:0] < `HS_MIN) begin
						done_ff  <= 1'b1;
						error_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end else begin
						hs_ff    <= nxt_hs;
						state_ff <= ST_FVCO;
					end
				end
				ST_FVCO: begin
					fvco_ff  <= fvco_calc;
					state_ff <= ST_RANGE;
				end
				ST_RANGE: begin
					// Upper limit is a parameter so a slower grade may be targeted
					if (fvco_ff < 48'(`FVCO_MIN_HZ) || fvco_ff > FVCO_MAX_HZ) begin
						done_ff  <= 1'b1;
						error_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end else begin
						state_ff <= ST_FB_LOAD;
					end
				end
				ST_FB_LOAD: begin
					ret_ff   <= ST_FB_EVAL;
					state_ff <= ST_DIVIDE;
				end
				ST_FB_EVAL: begin
					fb_ff    <= quo_ff[42:0];
					nfx_ff   <= nxt_nfx;
					state_ff <= ST_GAIN_LOAD;
				end
				ST_GAIN_LOAD: begin
					ret_ff   <= ST_GAIN_EVAL;
					state_ff <= ST_DIVIDE;
				end
				ST_GAIN_EVAL: begin
					result_ff.low_speed_divider_exponent  <= ls_exp_ff;
					result_ff.high_speed_divider          <= hs_ff;
					result_ff.feedback_divider_value      <= fb_ff;
					result_ff.control_adc_full_scale_gain <= quo_ff[7:0];
					done_ff  <= 1'b1;
					state_ff <= ST_IDLE;
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// ========================================
	// Assertions
	a_hs_odd_step: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_GAIN_EVAL |=> !(result_ff.high_speed_divider > `HS_ODD_MAX
			&& result_ff.high_speed_divider[0]))
		else $error("odd high speed divider above limit");

	a_hs_limits: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_GAIN_EVAL |-> hs_ff >= `HS_MIN && hs_ff <= `HS_MAX
			&& ls_exp_ff <= `LS_MAX_EXP)
		else $error("divider outside limits");

	a_vco_range: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_FB_LOAD |-> fvco_ff >= 48'(`FVCO_MIN_HZ) && fvco_ff <= FVCO_MAX_HZ
			&& fvco_ff == $past(fvco_calc, 2))
		else $error("vco frequency out of range");

	a_fb_truncate: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_FB_EVAL |->
			(80'(quo_ff[42:0]) * 80'(FOSC_HZ) <= {fvco_ff, 32'h0000_0000})
			&& ({fvco_ff, 32'h0000_0000} < 80'(quo_ff[42:0] + 43'h1) * 80'(FOSC_HZ)))
		else $error("feedback divider not truncated quotient");

	a_rate_table: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_GAIN_LOAD |->
			(fb_ff[42:32] < `FEEDBACK_INTEGER_PART_TH_18 && nfx_ff == `NFX_16)
			|| (fb_ff[42:32] >= `FEEDBACK_INTEGER_PART_TH_18 && fb_ff[42:32] < `FEEDBACK_INTEGER_PART_TH_20 && nfx_ff == `NFX_18)
			|| (fb_ff[42:32] >= `FEEDBACK_INTEGER_PART_TH_20 && fb_ff[42:32] < `FEEDBACK_INTEGER_PART_TH_22 && nfx_ff == `NFX_20)
			|| (fb_ff[42:32] >= `FEEDBACK_INTEGER_PART_TH_22 && nfx_ff == `NFX_22))
		else $error("rate divisor mismatch");

	a_gain_round: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_GAIN_EVAL |->
			(96'(quo_ff[15:0]) * 96'(fvco_ff) * 96'h2
				<= 96'(`GAIN_NUM) * 96'(nfx_ff) * 96'h2 + 96'(fvco_ff))
			&& (96'(`GAIN_NUM) * 96'(nfx_ff) * 96'h2 + 96'(fvco_ff)
				< 96'(quo_ff[15:0] + 16'h1) * 96'(fvco_ff) * 96'h2))
		else $error("gain not rounded quotient");

	a_start_clears: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_IDLE && start_req && fout_ff != 32'h0000_0000
			|=> !done_ff && !error_ff && state_ff == ST_HS_LOAD)
		else $error("start not taken");

	a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff != ST_GAIN_EVAL |=> $stable(result_ff))
		else $error("result changed outside completion");

	a_div_time: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_FB_LOAD |-> ##68 state_ff == ST_FB_EVAL)
		else $error("division length wrong");

	a_apb_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready_ff |=> !pready_ff)
		else $error("pready held too long");

	c_plan_ok: cover property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_GAIN_EVAL);
	c_plan_error: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(error_ff));
	c_low_ratio: cover property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_GAIN_EVAL && ls_exp_ff != 3'h0);
	c_odd_hs: cover property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_GAIN_EVAL && hs_ff[0]);

endmodule : vcxo_divider_planner

// ===== shared/vcxo_planner_defs.svh
// Constants for the oscillator divider planner
`ifndef VCXO_PLANNER_DEFS_SVH
`define VCXO_PLANNER_DEFS_SVH

// Register offsets
`define OFS_CTRL      12'h000
`define OFS_FOUT      12'h004
`define OFS_STATUS    12'h008
`define OFS_DIVIDERS  12'h00C
`define OFS_FB_FRAC   12'h010
`define OFS_FB_INT    12'h014
`define OFS_GAIN      12'h018

// Field positions
`define CTRL_START_BIT   0
`define STAT_BUSY_BIT    0
`define STAT_DONE_BIT    1
`define STAT_ERROR_BIT   2
`define DIVS_LS_LSB      0
`define DIVS_HS_LSB      8

// Frequencies in Hz
`define FVCO_MIN_HZ      36'h2_83BA_EC00
`define FVCO_MAX_DEFAULT 48'h0003_0E25_37C6
`define FOSC_DEFAULT     28'h918_7DC0
`define GAIN_NUM         38'h13_12D0_0000

// Divider limits
`define HS_MAX           11'h7FE
`define HS_MIN           11'h004
`define HS_ODD_MAX       11'h021
`define LS_MAX_EXP       3'h5

// Rate divisor table
`define FEEDBACK_INTEGER_PART_TH_18      11'h048
`define FEEDBACK_INTEGER_PART_TH_20      11'h04F
`define FEEDBACK_INTEGER_PART_TH_22      11'h056
`define NFX_16           5'h10
`define NFX_18           5'h12
`define NFX_20           5'h14
`define NFX_22           5'h16

// Serial divider
`define DIV_STEPS        7'h42

`endif

// ===== shared/vcxo_planner_pkg.sv
// Types for the oscillator divider planner
package vcxo_planner_pkg;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_HS_LOAD   = 4'b0001,
		ST_DIVIDE    = 4'b0010,
		ST_HS_EVAL   = 4'b0011,
		ST_FVCO      = 4'b0100,
		ST_RANGE     = 4'b0101,
		ST_FB_LOAD   = 4'b0110,
		ST_FB_EVAL   = 4'b0111,
		ST_GAIN_LOAD = 4'b1000,
		ST_GAIN_EVAL = 4'b1001
	} plan_state_type;

	typedef struct packed {
		logic [2:0]  low_speed_divider_exponent;
		logic [10:0] high_speed_divider;
		logic [42:0] feedback_divider_value;
		logic [7:0]  control_adc_full_scale_gain;
	} plan_result_type;

endpackage : vcxo_planner_pkg

// ===== test/vcxo_osc_model.sv
// Behavioural oscillator that takes the planner's divider values
`timescale 1ns/1ps
module vcxo_osc_model (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire vcxo_planner_pkg::plan_result_type plan_result,
	input  wire logic                              plan_done,
	output logic [5:0]                             ratio_ff,
	output logic [16:0]                            total_ff,
	output logic [42:0]                            fb_eff_ff
);
	import vcxo_planner_pkg::*;
	logic [5:0] nxt_ratio;
	// ====================
	// Divider loading
	always_comb begin
		if (plan_result.low_speed_divider_exponent >= 3'h5) begin
			nxt_ratio = 6'h20;
		end else begin
			nxt_ratio = 6'h01 << plan_result.low_speed_divider_exponent;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_ff  <= 6'h00;
			total_ff  <= 17'h0_0000;
			fb_eff_ff <= 43'h0;
		end else if (plan_done) begin
			ratio_ff  <= nxt_ratio;
			total_ff  <= {6'h00, plan_result.high_speed_divider} * nxt_ratio;
			// Control voltage at mid supply, scale factor one
			fb_eff_ff <= plan_result.feedback_divider_value;
		end
	end
endmodule : vcxo_osc_model

// ===== test/tb.sv
// Self-checking testbench for the divider planner
`timescale 1ns/1ps
`include "vcxo_planner_defs.svh"
module tb;
	import vcxo_planner_pkg::*;
	// ====================
	// Signals
	logic            pclk, presetn, psel, penable, pwrite;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata;
	logic            pready, pslverr, plan_done, plan_error;
	plan_result_type plan_result;
	logic [64:0]     last_res;
	logic [5:0]      osc_ratio;
	logic [16:0]     osc_total;
	logic [42:0]     osc_fb;
	int              error_cnt, checks, cyc;
	logic [31:0]     freqs [11] = '{32'h0000_0000, 32'h0957_D0B0, 32'h095B_0500,
		32'h13AB_6680, 32'h12E5_0940, 32'h000F_4240, 32'h0003_0D40, 32'h0001_86A0,
		32'hB8C6_3F00, 32'hD09D_C300, 32'hEE6B_2800};
	vcxo_divider_planner DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .plan_result(plan_result),
		.plan_done(plan_done), .plan_error(plan_error));
	vcxo_osc_model osc (.pclk(pclk), .presetn(presetn), .plan_result(plan_result),
		.plan_done(plan_done), .ratio_ff(osc_ratio), .total_ff(osc_total), .fb_eff_ff(osc_fb));
	// ====================
	// Clock and timeout
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			summarize();
		end
	end
	// ====================
	// Helpers
	task summarize;
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	task check(input logic [67:0] seen, input logic [67:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
		check(er, a > `OFS_GAIN);
	endtask : wr
	task rchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0000_0000, rd, er);
		check(er, 1'b0);
		check(rd, exp);
	endtask : rchk
	task wait_done;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (plan_done !== 1'b1 && n < 1000);
		check(plan_done, 1'b1);
	endtask : wait_done
	// Result laid out as {exponent, high divider, feedback, gain}
	function automatic logic [64:0] expect_plan(input logic [31:0] f, output logic err);
		logic [63:0] d, hs;
		logic [95:0] fvco, fb, nfx;
		int          k;
		err = (f == 0);
		if (err) return 65'h0;
		for (k = 0; k < 6; k++) begin
			d  = {32'h0000_0000, f} << k;
			hs = (`FVCO_MIN_HZ + d - 1) / d;
			if (hs > `HS_ODD_MAX && hs[0]) hs = hs + 1;
			if (hs <= `HS_MAX) break;
		end
		fvco = d * hs;
		err  = (k == 6) || (hs < `HS_MIN) || (fvco > `FVCO_MAX_DEFAULT);
		fb   = (fvco << 32) / `FOSC_DEFAULT;
		nfx  = (fb[42:32] < 72) ? 16 : (fb[42:32] < 79) ? 18 : (fb[42:32] < 86) ? 20 : 22;
		return {k[2:0], hs[10:0], fb[42:0], 8'(((`GAIN_NUM * nfx) + fvco / 2) / fvco)};
	endfunction : expect_plan
	// ====================
	// Scenarios
	task t_regs;
		logic [31:0] rd;
		logic        er;
		rchk(`OFS_FOUT, 32'h0000_0000);
		rchk(`OFS_STATUS, 32'h0000_0000);
		rchk(`OFS_DIVIDERS, 32'h0000_0000);
		wr(`OFS_GAIN, 32'h0000_00FF);
		rchk(`OFS_GAIN, 32'h0000_0000);
		rchk(`OFS_CTRL, 32'h0000_0000);
		apb(1'b0, 12'h01C, 32'h0000_0000, rd, er);
		check(er, 1'b1);
		wr(12'h01C, 32'h0000_0001);
	endtask : t_regs
	task t_plan(input logic [31:0] f);
		logic [64:0] e;
		logic        err;
		e = expect_plan(f, err);
		wr(`OFS_FOUT, f);
		wr(`OFS_CTRL, 32'h0000_0001);
		wait_done();
		check(plan_error, err);
		if (err) begin
			check(plan_result, last_res);
		end else begin
			check(plan_result, e);
			rchk(`OFS_DIVIDERS, {13'h0000, e[61:51], 5'h00, e[64:62]});
			rchk(`OFS_FB_FRAC, e[39:8]);
			rchk(`OFS_FB_INT, {21'h00_0000, e[50:40]});
			rchk(`OFS_GAIN, {24'h00_0000, e[7:0]});
			check(osc_ratio, 6'h01 << e[64:62]);
			check(osc_total, {6'h00, e[61:51]} << e[64:62]);
			check(osc_fb, e[50:8]);
			last_res = e;
		end
	endtask : t_plan
	task t_busy;
		wr(`OFS_FOUT, 32'h0957_D0B0);
		wr(`OFS_CTRL, 32'h0000_0001);
		rchk(`OFS_STATUS, 32'h0000_0001);
		wr(`OFS_FOUT, 32'h000F_4240);
		wr(`OFS_CTRL, 32'h0000_0001);
		rchk(`OFS_FOUT, 32'h0957_D0B0);
		wait_done();
		rchk(`OFS_STATUS, 32'h0000_0002);
		rchk(`OFS_DIVIDERS, 32'h0000_4600);
		rchk(`OFS_FB_INT, 32'h0000_0047);
		rchk(`OFS_FB_FRAC, 32'hE756_E62A);
		rchk(`OFS_GAIN, 32'h0000_0077);
	endtask : t_busy
	// Reset in the middle of a plan
	task t_reset;
		wr(`OFS_CTRL, 32'h0000_0001);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check(plan_result, 65'h0);
		check({plan_done, plan_error, pready}, 3'h0);
		presetn <= 1'b1;
		rchk(`OFS_FOUT, 32'h0000_0000);
		rchk(`OFS_STATUS, 32'h0000_0000);
	endtask : t_reset
	// ====================
	// Main sequence
	initial begin
		presetn  = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h0000_0000;
		last_res = 65'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		foreach (freqs[i]) t_plan(freqs[i]);
		t_busy();
		t_reset();
		summarize();
	end
endmodule : tb
